//--- src/twm_pkg.sv
/*
 * Constants, command and status types for the two-wire bus master.
 * Assumes a 40 MHz system clock and a host port on a separate clock.
 */
// ----------
// Overview of operation
// - Three speeds (100 kbit/s, 400 kbit/s, 1 Mbit/s) are selectable per command.
// - A write sends the address with write direction, then every data byte.
// - A read turns the master into receiver after the address; it acks all but the last byte.
// - The last read byte gets a not-acknowledge, followed by a stop.
// - A combined read sends start, address+write, 0 to 4 command bytes, repeated start, read.
// - After the repeated start the same address goes out with the direction bit inverted.
// - An address-only transfer is start, address with direction bit, then stop.
// - A slave holding the clock low is waited for before the bit sequence continues.
// - The clock is held low while the receive buffer is full or the send buffer empty.
// - A configurable response limit ends the transfer as failed when it expires.
// ----------
package twm_pkg;

   // ----------
   // Clock and bit timing
   // ----------
   localparam int CLK_MHZ = 40;
   localparam int RATE_SM_KBPS = 100;
   localparam int RATE_FM_KBPS = 400;
   localparam int RATE_FMP_KBPS = 1000;
   localparam int T_LOW_SM_NS = 4700;
   localparam int T_LOW_FM_NS = 1300;
   localparam int T_LOW_FMP_NS = 500;
   localparam int BIT_SM_CYC = CLK_MHZ * 1000 / RATE_SM_KBPS;
   localparam int BIT_FM_CYC = CLK_MHZ * 1000 / RATE_FM_KBPS;
   localparam int BIT_FMP_CYC = CLK_MHZ * 1000 / RATE_FMP_KBPS;
   // Least times round up
   localparam logic [8:0] LOW_SM_CYC = 9'((T_LOW_SM_NS * CLK_MHZ + 999) / 1000);
   localparam logic [8:0] LOW_FM_CYC = 9'((T_LOW_FM_NS * CLK_MHZ + 999) / 1000);
   localparam logic [8:0] LOW_FMP_CYC = 9'((T_LOW_FMP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [8:0] HIGH_SM_CYC = 9'(BIT_SM_CYC) - LOW_SM_CYC;
   localparam logic [8:0] HIGH_FM_CYC = 9'(BIT_FM_CYC) - LOW_FM_CYC;
   localparam logic [8:0] HIGH_FMP_CYC = 9'(BIT_FMP_CYC) - LOW_FMP_CYC;
   // Timeout counts in microseconds
   localparam int TICK_NS = 1000;
   localparam logic [5:0] TICK_CYC = 6'(TICK_NS * CLK_MHZ / 1000);
   localparam logic [7:0] CMD_BYTES_MAX = 8'h04;

   // ----------
   // Types
   // ----------
   typedef enum logic [1:0] {
      TWM_WRITE = 2'h0,
      TWM_READ = 2'h1,
      TWM_RANDOM = 2'h2,
      TWM_ADDR = 2'h3
   } twm_mode_t;

   typedef enum logic [1:0] {
      TWM_SM = 2'h0,
      TWM_FM = 2'h1,
      TWM_FMP = 2'h2
   } twm_speed_t;

   typedef struct packed {
      twm_mode_t mode;
      twm_speed_t speed;
      logic [6:0] addr;
      logic rd;            // Direction bit, address-only transfers
      logic [7:0] wr_len;  // Write or command byte count
      logic [7:0] rd_len;  // Read byte count, 0 means 256
      logic [15:0] tmo_us; // Response limit, 0 disables
   } twm_cmd_t;

   typedef struct packed {
      logic nack_addr;
      logic nack_data;
      logic timeout;
   } twm_status_t;

endpackage : twm_pkg

//--- src/twm_master.sv
/*
 * Two-wire bus master: bit engine on the system clock, host command and
 * data ports on the host clock, joined by toggle handshakes and two
 * gray-pointer FIFOs. Assumes external pull-ups on both bus lines.
 */
`timescale 1ns/10ps

// ----------
// Dual-clock FIFO
// ----------
module twm_afifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   // Write side
   input wire logic clk_w_i,
   input wire logic w_valid_i,
   output logic w_ready_o,
   input wire logic [W-1:0] w_data_i,
   // Read side
   input wire logic clk_r_i,
   output logic r_valid_o,
   input wire logic r_ready_i,
   output logic [W-1:0] r_data_o,
   // Reset
   input wire logic arst_n_i
);
   localparam int A = $clog2(D);
   logic [W-1:0] mem [D];
   logic [A:0] wbin, wgray, rbin, rgray;
   logic [A:0] wg_s1, wg_s2, rg_s1, rg_s2;
   logic [A:0] next_wbin, next_rbin;

   assign next_wbin = wbin + (A+1)'(1);
   assign next_rbin = rbin + (A+1)'(1);
   // Full when the pointers differ only in their two top gray bits
   assign w_ready_o = (wgray != {~rg_s2[A:A-1], rg_s2[A-2:0]});
   assign r_valid_o = (rgray != wg_s2);
   assign r_data_o = mem[rbin[A-1:0]];

   // Write pointer and storage
   always_ff @(posedge clk_w_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wbin <= '0;
         wgray <= '0;
      end else if (w_valid_i && w_ready_o) begin
         wbin <= next_wbin;
         wgray <= next_wbin ^ (next_wbin >> 1);
      end
   end

   always_ff @(posedge clk_w_i) begin
      if (w_valid_i && w_ready_o) begin
         mem[wbin[A-1:0]] <= w_data_i;
      end
   end

   // Read pointer
   always_ff @(posedge clk_r_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rbin <= '0;
         rgray <= '0;
      end else if (r_valid_o && r_ready_i) begin
         rbin <= next_rbin;
         rgray <= next_rbin ^ (next_rbin >> 1);
      end
   end

   // Pointer synchronisers
   always_ff @(posedge clk_r_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wg_s1 <= '0;
         wg_s2 <= '0;
      end else begin
         wg_s1 <= wgray;
         wg_s2 <= wg_s1;
      end
   end

   always_ff @(posedge clk_w_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rg_s1 <= '0;
         rg_s2 <= '0;
      end else begin
         rg_s1 <= rgray;
         rg_s2 <= rg_s1;
      end
   end
endmodule : twm_afifo

// ----------
// Bus master top
// ----------
module twm_master (
   // System clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // Host side, host clock domain
   input wire logic clk_host_i,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire twm_pkg::twm_cmd_t cmd_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   input wire logic [7:0] tx_data_i,
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   output logic [7:0] rx_data_o,
   output logic done_o,
   output twm_pkg::twm_status_t status_o,
   // Bus pins
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o
);
   import twm_pkg::*;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_START = 5'h02,
      ST_LOW = 5'h04,
      ST_HIGH = 5'h08,
      ST_STOP = 5'h10
   } twm_state_t;

   typedef enum logic [1:0] {
      P_ADR1 = 2'h0,
      P_WR = 2'h1,
      P_ADR2 = 2'h2,
      P_RD = 2'h3
   } twm_phase_t;

   // ----------
   // Host domain: command launch and completion
   // ----------
   twm_cmd_t cmd_h;
   twm_status_t sts_s;
   logic busy_h, req_tgl_h, ack_h1, ack_h2, ack_h3;
   logic ack_tgl_s, req_s1, req_s2, req_s3;

   assign cmd_ready_o = ~busy_h;

   // Command held stable in cmd_h until the engine answers
   always_ff @(posedge clk_host_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy_h <= 1'b0;
         req_tgl_h <= 1'b0;
         cmd_h <= '0;
         ack_h1 <= 1'b0;
         ack_h2 <= 1'b0;
         ack_h3 <= 1'b0;
         done_o <= 1'b0;
         status_o <= '0;
      end else begin
         ack_h1 <= ack_tgl_s;
         ack_h2 <= ack_h1;
         ack_h3 <= ack_h2;
         done_o <= ack_h2 ^ ack_h3;
         if (ack_h2 ^ ack_h3) begin
            busy_h <= 1'b0;
            status_o <= sts_s;
         end else if (cmd_valid_i && !busy_h) begin
            busy_h <= 1'b1;
            cmd_h <= cmd_i;
            req_tgl_h <= ~req_tgl_h;
         end
      end
   end

   // ----------
   // Data buffers between the domains
   // ----------
   logic txf_valid, txf_pop, rxf_ready, rxf_push;
   logic [7:0] txf_data, rx_byte;

   twm_afifo #(.W(8), .D(4)) u_txf (
      .clk_w_i(clk_host_i), .w_valid_i(tx_valid_i), .w_ready_o(tx_ready_o),
      .w_data_i(tx_data_i), .clk_r_i(clk_sys_i), .r_valid_o(txf_valid),
      .r_ready_i(txf_pop), .r_data_o(txf_data), .arst_n_i(arst_n_i)
   );

   twm_afifo #(.W(8), .D(4)) u_rxf (
      .clk_w_i(clk_sys_i), .w_valid_i(rxf_push), .w_ready_o(rxf_ready),
      .w_data_i(rx_byte), .clk_r_i(clk_host_i), .r_valid_o(rx_valid_o),
      .r_ready_i(rx_ready_i), .r_data_o(rx_data_o), .arst_n_i(arst_n_i)
   );

   // ----------
   // System domain synchronisers
   // ----------
   logic scl_s1, scl_s2, sda_s1, sda_s2;

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         {scl_s1, scl_s2, sda_s1, sda_s2} <= 4'hF;
         {req_s1, req_s2, req_s3} <= 3'h0;
      end else begin
         scl_s1 <= scl_i;
         scl_s2 <= scl_s1;
         sda_s1 <= sda_i;
         sda_s2 <= sda_s1;
         req_s1 <= req_tgl_h;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
      end
   end

   // ----------
   // Bit engine
   // ----------
   twm_state_t state;
   twm_phase_t phase;
   twm_cmd_t cmd;
   logic [1:0] step;
   logic [8:0] cnt, lo_cyc, hi_cyc;
   logic [3:0] bitn;
   logic [7:0] shreg, wr_left, rd_left;
   logic smp, scl_drv, sda_drv, waiting, tmo_hit, stall, tx_ph;
   logic [5:0] tick;
   logic [15:0] tmo_us;

   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_o = scl_drv;
   assign sda_oe_o = sda_drv;
   assign tx_ph = (phase != P_RD);
   // Waiting for the clock line to read high after our side has released it
   assign waiting = !scl_s2 && !scl_drv && (state != ST_IDLE);
   assign tmo_hit = waiting && (cmd.tmo_us != 16'h0000) && (tmo_us == cmd.tmo_us);
   // Clock stays low while a byte cannot be fed or stored
   assign stall = (cnt == 9'h000) && (((phase == P_WR) && (bitn == 4'h0) && !txf_valid)
                  || ((phase == P_RD) && (bitn == 4'h8) && !rxf_ready));
   assign txf_pop = (state == ST_LOW) && !stall && (cnt == 9'h000)
                    && (phase == P_WR) && (bitn == 4'h0);
   assign rxf_push = (state == ST_LOW) && !stall && (cnt == 9'h000)
                     && (phase == P_RD) && (bitn == 4'h8);
   assign rx_byte = shreg;

   // Response timer in microsecond ticks, cleared once the clock rises
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tick <= 6'h00;
         tmo_us <= 16'h0000;
      end else if (!waiting) begin
         tick <= 6'h00;
         tmo_us <= 16'h0000;
      end else if (tick == TICK_CYC - 6'h01) begin
         tick <= 6'h00;
         tmo_us <= tmo_us + 16'h0001;
      end else begin
         tick <= tick + 6'h01;
      end
   end

   // Transfer sequencer
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= ST_IDLE;
         phase <= P_ADR1;
         cmd <= '0;
         step <= 2'h0;
         cnt <= 9'h000;
         lo_cyc <= LOW_SM_CYC;
         hi_cyc <= HIGH_SM_CYC;
         bitn <= 4'h0;
         shreg <= 8'h00;
         wr_left <= 8'h00;
         rd_left <= 8'h00;
         smp <= 1'b1;
         scl_drv <= 1'b0;
         sda_drv <= 1'b0;
         sts_s <= '0;
         ack_tgl_s <= 1'b0;
      end else if (tmo_hit) begin
         // Slave never let go: free our side and report
         scl_drv <= 1'b0;
         sda_drv <= 1'b0;
         sts_s.timeout <= 1'b1;
         ack_tgl_s <= ~ack_tgl_s;
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (req_s2 ^ req_s3) begin
                  cmd <= cmd_h;
                  sts_s <= '0;
                  case (cmd_h.speed)
                     TWM_FM: begin
                        lo_cyc <= LOW_FM_CYC;
                        hi_cyc <= HIGH_FM_CYC;
                     end
                     TWM_FMP: begin
                        lo_cyc <= LOW_FMP_CYC;
                        hi_cyc <= HIGH_FMP_CYC;
                     end
                     default: begin
                        lo_cyc <= LOW_SM_CYC;
                        hi_cyc <= HIGH_SM_CYC;
                     end
                  endcase
                  phase <= P_ADR1;
                  // Write and combined reads open with write direction
                  shreg <= {cmd_h.addr, (cmd_h.mode == TWM_READ)
                            || ((cmd_h.mode == TWM_ADDR) && cmd_h.rd)};
                  wr_left <= ((cmd_h.mode == TWM_RANDOM) && (cmd_h.wr_len > CMD_BYTES_MAX))
                             ? CMD_BYTES_MAX : cmd_h.wr_len;
                  rd_left <= cmd_h.rd_len;
                  step <= 2'h1;
                  cnt <= 9'h000;
                  state <= ST_START;
               end
            end
            ST_START: begin
               if (step == 2'h0) begin
                  // Clock low with data released ahead of a repeated start
                  scl_drv <= 1'b1;
                  sda_drv <= (cnt < (lo_cyc >> 1)) ? sda_drv : 1'b0;
                  cnt <= cnt + 9'h001;
                  if (cnt == lo_cyc - 9'h001) begin
                     scl_drv <= 1'b0;
                     cnt <= 9'h000;
                     step <= 2'h1;
                  end
               end else if (scl_s2 && !scl_drv) begin
                  cnt <= cnt + 9'h001;
                  if (cnt == hi_cyc - 9'h001) begin
                     cnt <= 9'h000;
                     if (step == 2'h1) begin
                        sda_drv <= 1'b1; // Data falls while clock is high
                        step <= 2'h2;
                     end else begin
                        scl_drv <= 1'b1;
                        bitn <= 4'h0;
                        state <= ST_LOW;
                     end
                  end
               end
            end
            ST_LOW: begin
               if (!stall) begin
                  cnt <= cnt + 9'h001;
               end
               if (txf_pop) begin
                  shreg <= txf_data;
               end
               if (cnt == (lo_cyc >> 1)) begin
                  if (bitn != 4'h8) begin
                     sda_drv <= tx_ph ? ~shreg[7] : 1'b0;
                  end else begin
                     // Ack every read byte but the last, which gets a nack
                     sda_drv <= (phase == P_RD) && (rd_left != 8'h01);
                  end
               end
               if (cnt == lo_cyc - 9'h001) begin
                  cnt <= 9'h000;
                  scl_drv <= 1'b0;
                  state <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (scl_s2) begin
                  cnt <= cnt + 9'h001;
                  if (cnt == 9'h000) begin
                     smp <= sda_s2;
                  end
               end
               if (scl_s2 && (cnt == hi_cyc - 9'h001)) begin
                  cnt <= 9'h000;
                  scl_drv <= 1'b1;
                  state <= ST_LOW;
                  if (bitn != 4'h8) begin
                     bitn <= bitn + 4'h1;
                     shreg <= tx_ph ? {shreg[6:0], 1'b0} : {shreg[6:0], smp};
                  end else begin
                     bitn <= 4'h0;
                     if (tx_ph && smp) begin
                        // No acknowledge from the slave: abandon with a stop
                        if (phase == P_WR) begin
                           sts_s.nack_data <= 1'b1;
                        end else begin
                           sts_s.nack_addr <= 1'b1;
                        end
                        state <= ST_STOP;
                        step <= 2'h0;
                     end else begin
                        case (phase)
                           P_ADR1: begin
                              if (cmd.mode == TWM_READ) begin
                                 phase <= P_RD;
                              end else if (cmd.mode == TWM_ADDR) begin
                                 state <= ST_STOP;
                                 step <= 2'h0;
                              end else if (wr_left != 8'h00) begin
                                 phase <= P_WR;
                              end else if (cmd.mode == TWM_RANDOM) begin
                                 phase <= P_ADR2;
                                 shreg <= {cmd.addr, 1'b1};
                                 state <= ST_START;
                                 step <= 2'h0;
                              end else begin
                                 state <= ST_STOP;
                                 step <= 2'h0;
                              end
                           end
                           P_WR: begin
                              wr_left <= wr_left - 8'h01;
                              if ((wr_left == 8'h01) && (cmd.mode == TWM_RANDOM)) begin
                                 phase <= P_ADR2;
                                 shreg <= {cmd.addr, 1'b1};
                                 state <= ST_START;
                                 step <= 2'h0;
                              end else if (wr_left == 8'h01) begin
                                 state <= ST_STOP;
                                 step <= 2'h0;
                              end
                           end
                           P_ADR2: begin
                              phase <= P_RD;
                           end
                           default: begin
                              rd_left <= rd_left - 8'h01;
                              if (rd_left == 8'h01) begin
                                 state <= ST_STOP;
                                 step <= 2'h0;
                              end
                           end
                        endcase
                     end
                  end
               end
            end
            ST_STOP: begin
               if (step == 2'h0) begin
                  // Data goes low while the clock is low, then the clock rises
                  cnt <= cnt + 9'h001;
                  if (cnt == (lo_cyc >> 1)) begin
                     sda_drv <= 1'b1;
                  end
                  if (cnt == lo_cyc - 9'h001) begin
                     cnt <= 9'h000;
                     scl_drv <= 1'b0;
                     step <= 2'h1;
                  end
               end else if (step == 2'h1) begin
                  if (scl_s2) begin
                     cnt <= cnt + 9'h001;
                  end
                  if (scl_s2 && (cnt == hi_cyc - 9'h001)) begin
                     cnt <= 9'h000;
                     sda_drv <= 1'b0; // Stop: data rises with clock high
                     step <= 2'h2;
                  end
               end else begin
                  // Bus free time before the engine may start again
                  cnt <= cnt + 9'h001;
                  if (cnt == lo_cyc - 9'h001) begin
                     cnt <= 9'h000;
                     ack_tgl_s <= ~ack_tgl_s;
                     state <= ST_IDLE;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule : twm_master

//--- verif/twm_master_monitor.sv
/* Pin and handshake checker for the two-wire bus master.
   Assumes it is bound into twm_master and sees only its ports. */
`timescale 1ns/10ps
module twm_master_monitor (
   // Clocks and reset
   input wire logic clk_sys_i,
   input wire logic clk_host_i,
   input wire logic arst_n_i,
   // Host side
   input wire logic cmd_ready_o,
   input wire logic rx_valid_o,
   input wire logic rx_ready_i,
   input wire logic [7:0] rx_data_o,
   input wire logic done_o,
   input wire twm_pkg::twm_status_t status_o,
   // Bus pins
   input wire logic scl_i,
   input wire logic scl_oe_o,
   input wire logic sda_oe_o
);
   import twm_pkg::*;
   int lo_cnt;
   int hi_cnt;
   // Lengths of the driven-low and released phases of the clock line
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lo_cnt <= 0;
         hi_cnt <= 0;
      end else begin
         lo_cnt <= scl_oe_o ? lo_cnt + 1 : 0;
         hi_cnt <= scl_oe_o ? 0 : hi_cnt + 1;
      end
   end
   property p_lo_min;
      @(posedge clk_sys_i) disable iff (!arst_n_i) $fell(scl_oe_o) |-> lo_cnt >= int'(LOW_FMP_CYC);
   endproperty
   a_lo_min: assert property (p_lo_min) else $error("clock low phase too short");
   property p_hi_min;
      @(posedge clk_sys_i) disable iff (!arst_n_i) $rose(scl_oe_o) |-> hi_cnt >= int'(HIGH_FMP_CYC);
   endproperty
   a_hi_min: assert property (p_hi_min) else $error("clock high phase too short");
   property p_start;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         $rose(sda_oe_o) && !scl_oe_o && scl_i |=> (sda_oe_o && !scl_oe_o) [*8];
   endproperty
   a_start: assert property (p_start) else $error("start hold too short");
   property p_stop;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         $fell(sda_oe_o) && !scl_oe_o && scl_i |=> (!sda_oe_o && !scl_oe_o) [*8];
   endproperty
   a_stop: assert property (p_stop) else $error("bus free time too short");
   property p_stretch;
      @(posedge clk_sys_i) disable iff (!arst_n_i) !scl_oe_o && !scl_i |=> !scl_oe_o [*8];
   endproperty
   a_stretch: assert property (p_stretch) else $error("clock driven during stretch");
   property p_ready_done;
      @(posedge clk_host_i) disable iff (!arst_n_i) $rose(cmd_ready_o) |-> done_o;
   endproperty
   a_ready_done: assert property (p_ready_done) else $error("idle without done");
   property p_done_pulse;
      @(posedge clk_host_i) disable iff (!arst_n_i) done_o |=> !done_o;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
   property p_rx_hold;
      @(posedge clk_host_i) disable iff (!arst_n_i)
         rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o);
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("read byte dropped in stall");
   // Main scenarios reached
   c_tmo: cover property (@(posedge clk_host_i) done_o && status_o.timeout);
   c_nack: cover property (@(posedge clk_host_i) done_o && status_o.nack_addr);
   c_hold: cover property (@(posedge clk_sys_i) !scl_oe_o && !scl_i);
endmodule : twm_master_monitor
bind twm_master twm_master_monitor MON (.clk_sys_i, .clk_host_i, .arst_n_i, .cmd_ready_o,
   .rx_valid_o, .rx_ready_i, .rx_data_o, .done_o, .status_o, .scl_i, .scl_oe_o, .sda_oe_o);

//--- verif/twm_slave_model.sv
/* Behavioural two-wire slave for the master bench.
   Assumes open-drain lines resolved with pull-ups by the bench. */
`timescale 1ns/10ps
module twm_slave_model (
   // Resolved bus lines
   input wire logic scl_i,
   input wire logic sda_i,
   // Bench controls
   input wire logic [6:0] addr_i,
   input wire logic nack_data_i,
   input wire logic stretch_i,
   input wire logic hold_i,
   // Line pull-downs
   output logic scl_pd_o = 1'b0,
   output logic sda_pd_o = 1'b0
);
   int bitc = 0, idx = 0;
   logic first = 1'b0, act = 1'b0, rd = 1'b0;
   logic [7:0] sh = 8'h00, rb = 8'h00, adr = 8'h00, got[$];
   // Start or repeated start: an address byte follows
   always @(negedge sda_i) if (scl_i) begin
      bitc = 0;
      first = 1'b1;
   end
   // Stop ends the frame
   always @(posedge sda_i) if (scl_i) act = 1'b0;
   // Sample on the rising clock; a high ninth bit from the master ends reading
   always @(posedge scl_i) begin
      if (bitc == 8) begin
         if (rd && sda_i) act = 1'b0;
         idx = idx + 1;
         bitc = 0;
      end else begin
         sh = {sh[6:0], sda_i};
         bitc = bitc + 1;
      end
   end
   // Drive on the falling clock so data is steady while the clock is high
   always @(negedge scl_i) begin
      sda_pd_o = 1'b0;
      rb = 8'hC3 ^ 8'(idx);
      if (bitc == 8 && first) begin
         adr = sh;
         act = sh[7:1] == addr_i;
         rd = sh[0];
         first = 1'b0;
         idx = 0;
         sda_pd_o = act;
      end else if (bitc == 8 && act && !rd) begin
         got.push_back(sh);
         sda_pd_o = !nack_data_i;
      end else if (bitc < 8 && act && rd && !first) begin
         sda_pd_o = !rb[7-bitc];
      end
      if (hold_i || stretch_i) scl_pd_o = 1'b1;
      if (stretch_i && !hold_i) scl_pd_o <= #3000 1'b0;
   end
   // Giving up a long hold frees both lines
   always @(negedge hold_i) begin
      scl_pd_o = 1'b0;
      sda_pd_o = 1'b0;
   end
endmodule : twm_slave_model

//--- verif/twm_master_tb.sv
/* Self-checking bench for twm_master against a behavioural slave.
   Assumes the package, design and slave model are compiled first. */
`timescale 1ns/10ps
module twm_master_tb;
   import twm_pkg::*;
   logic clk_sys_i = 0, clk_host_i = 0, arst_n_i = 0, cmd_valid_i = 0, tx_valid_i = 0;
   logic rx_ready_i = 0, nack_d = 0, str = 0, hold = 0, scl_pd, sda_pd;
   logic cmd_ready_o, tx_ready_o, rx_valid_o, done_o, scl_o, sda_o, scl_oe_o, sda_oe_o;
   logic [7:0] tx_data_i = 8'h00, rx_data_o, lf = 8'h1F, tq[$];
   twm_cmd_t cmd_i = '0;
   twm_status_t status_o;
   int failures = 0, compares = 0, cyc = 0;
   wire logic scl_w = !(scl_oe_o | scl_pd);
   wire logic sda_w = !(sda_oe_o | sda_pd);
   initial forever #12.5 clk_sys_i = !clk_sys_i;
   initial #3.7 forever #6 clk_host_i = !clk_host_i;
   twm_master DUT (.clk_sys_i, .arst_n_i, .clk_host_i, .cmd_valid_i, .cmd_ready_o, .cmd_i,
      .tx_valid_i, .tx_ready_o, .tx_data_i, .rx_valid_o, .rx_ready_i, .rx_data_o, .done_o,
      .status_o, .scl_i(scl_w), .scl_o, .scl_oe_o, .sda_i(sda_w), .sda_o, .sda_oe_o);
   twm_slave_model SLV (.scl_i(scl_w), .sda_i(sda_w), .addr_i(7'h2A), .nack_data_i(nack_d),
      .stretch_i(str), .hold_i(hold), .scl_pd_o(scl_pd), .sda_pd_o(sda_pd));
   function automatic logic [7:0] rnd();
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      return lf;
   endfunction : rnd
   task automatic hc();
      @(posedge clk_host_i);
      #1;
   endtask : hc
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic final_report();
      if (failures == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
   // One transfer: command, write feed with gaps, read drain with stalls
   task automatic xfer(input twm_mode_t m, input twm_speed_t s, input logic [6:0] a,
         input int wl, input int nr, input logic [15:0] tmo, input logic [2:0] st);
      fork
         begin
            cmd_i = '{m, s, a, wl == 0, 8'(wl), 8'(nr), tmo};
            cmd_valid_i = 1;
            while (!cmd_ready_o) hc();
            hc();
            cmd_valid_i = 0;
            while (!done_o) hc();
            chk("status", 16'(status_o), 16'(st));
            chk("pins", 16'({scl_o, sda_o}), 16'h0000);
         end
         for (int i = 0; i < ((m == TWM_WRITE || m == TWM_RANDOM) ? wl : 0); i++) begin
            repeat (i == 1 ? 2000 : rnd() % 4 + 1) hc();
            tx_data_i = rnd();
            tq.push_back(tx_data_i);
            tx_valid_i = 1;
            while (!tx_ready_o) hc();
            hc();
            tx_valid_i = 0;
         end
         for (int i = 0; i < nr; i++) begin
            repeat (i == 0 ? 4000 : rnd() % 8 + 1) hc();
            rx_ready_i = 1;
            while (!rx_valid_o) hc();
            chk("rx_data", 16'(rx_data_o), 16'(8'hC3 ^ 8'(i + 1)));
            hc();
            rx_ready_i = 0;
         end
      join
      if (st == 3'h0)
         chk("adr", 16'(SLV.adr), 16'({a, !(m == TWM_ADDR ? wl : m == TWM_WRITE)}));
      chk("wr_count", 16'(SLV.got.size()), 16'(tq.size()));
      foreach (tq[i]) chk("wr_data", 16'(SLV.got[i]), 16'(tq[i]));
      SLV.got.delete();
      tq.delete();
   endtask : xfer
   // Cycle ceiling against hangs
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 90000) begin
         failures++;
         final_report();
      end
   end
   initial begin
      repeat (5) @(posedge clk_sys_i);
      #1 arst_n_i = 1;
      xfer(TWM_WRITE, TWM_FMP, 7'h2A, 3, 0, 16'h0, 3'h0);
      str = 1;
      xfer(TWM_WRITE, TWM_FM, 7'h2A, 2, 0, 16'h0, 3'h0);
      str = 0;
      xfer(TWM_READ, TWM_FMP, 7'h2A, 0, 6, 16'h0, 3'h0);
      xfer(TWM_RANDOM, TWM_SM, 7'h2A, 2, 1, 16'h0, 3'h0);
      xfer(TWM_RANDOM, TWM_FMP, 7'h2A, 0, 2, 16'h0, 3'h0);
      xfer(TWM_RANDOM, TWM_FM, 7'h2A, 4, 1, 16'h0, 3'h0);
      xfer(TWM_ADDR, TWM_FMP, 7'h2A, 0, 0, 16'h0, 3'h0);
      xfer(TWM_ADDR, TWM_FM, 7'h15, 0, 0, 16'h0, 3'h4);
      nack_d = 1;
      xfer(TWM_WRITE, TWM_FMP, 7'h2A, 1, 0, 16'h0, 3'h2);
      nack_d = 0;
      hold = 1;
      xfer(TWM_ADDR, TWM_FMP, 7'h2A, 0, 0, 16'h3, 3'h1);
      hold = 0;
      xfer(TWM_ADDR, TWM_FMP, 7'h2A, 1, 0, 16'h0, 3'h0);
      final_report();
   end
endmodule : twm_master_tb
